// File: verilog/sid_readout.sv
// Bus target of the flow sensor: identity readout, measurement words, checksums.
// Assumes an open-drain data line resolved outside and a measurement core on clk_in.
`default_nettype none
module sid_readout #(
	parameter logic [6:0] DEV_ADDR = 7'h10,
	// Arbitrary value; low byte is the revision
	parameter logic [31:0] PRODUCT_ID = 32'h0a0b0c01
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oen_out,
	// Sensing core
	input wire sid_pkg::sid_meas_s meas_in,
	input wire logic meas_active_in,
	input wire logic [63:0] serial_in,
	// Status
	output logic id_ready_out
);
	// Address range check: reserved addresses cannot be served
	if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_chk
		$error("DEV_ADDR lies in a reserved range");
	end

	// Reset release synchroniser
	logic rst_s1_ff, rst_n;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_s1_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n <= rst_s1_ff;
		end
	end

	// Pin synchronisers plus one delayed copy for edges
	logic scl_s1_ff, scl_s2_ff, scl_d_ff;
	logic sda_s1_ff, sda_s2_ff, sda_d_ff;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_s1_ff <= scl_in;
			scl_s2_ff <= scl_s1_ff;
			scl_d_ff <= scl_s2_ff;
			sda_s1_ff <= sda_in;
			sda_s2_ff <= sda_s1_ff;
			sda_d_ff <= sda_s2_ff;
		end
	end

	// Bus events on the synchronised copies
	logic rise, fall, start, stop;
	assign rise = scl_s2_ff & ~scl_d_ff;
	assign fall = ~scl_s2_ff & scl_d_ff;
	assign start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
	assign stop = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

	// Target state
	sid_pkg::sid_state_e st_ff, nxt_st;
	logic [7:0] sh_ff, nxt_sh; // Receive shifter
	logic [7:0] tx_ff, nxt_tx; // Transmit shifter
	logic [3:0] cnt_ff, nxt_cnt; // Bits in this byte
	logic oen_ff, nxt_oen; // Low pulls the data line
	logic rw_ff, nxt_rw; // Read header seen
	logic [7:0] hi_ff, nxt_hi; // First command byte
	logic wb_ff, nxt_wb; // Second command byte due
	logic stage_ff, nxt_stage; // First id command taken
	logic rdy_ff, nxt_rdy; // Identity read armed
	logic msel_ff, nxt_msel; // This read returns measurements
	logic [1:0] pos_ff, nxt_pos; // Byte within word
	logic [2:0] word_ff, nxt_word; // Word index
	logic acked_ff, nxt_acked; // Host acked last byte

	// Flow clamp keeps codes inside the output limit
	logic signed [15:0] flow_cl;
	always_comb begin
		if (meas_in.flow > sid_pkg::FLOW_MAX) begin
			flow_cl = sid_pkg::FLOW_MAX;
		end else if (meas_in.flow < sid_pkg::FLOW_MIN) begin
			flow_cl = sid_pkg::FLOW_MIN;
		end else begin
			flow_cl = meas_in.flow;
		end
	end

	// Word selected for the current read position
	logic [15:0] wd;
	logic [2:0] nwords;
	always_comb begin
		wd = 16'h0000;
		nwords = msel_ff ? sid_pkg::MEAS_WORDS : sid_pkg::ID_WORDS;
		if (msel_ff) begin
			case (word_ff)
				3'h0: wd = flow_cl;
				3'h1: wd = meas_in.temp;
				default: wd = 16'h0000;
			endcase
		end else begin
			case (word_ff)
				3'h0: wd = PRODUCT_ID[31:16];
				3'h1: wd = PRODUCT_ID[15:0];
				3'h2: wd = serial_in[63:48];
				3'h3: wd = serial_in[47:32];
				3'h4: wd = serial_in[31:16];
				3'h5: wd = serial_in[15:0];
				default: wd = 16'h0000;
			endcase
		end
	end

	// Byte to send; checksum only over this word's two bytes
	logic [7:0] tx_byte;
	always_comb begin
		if (word_ff >= nwords) begin
			tx_byte = sid_pkg::FILL_BYTE; // Past the end
		end else if (pos_ff == sid_pkg::CRC_POS) begin
			tx_byte = sid_pkg::sid_crc8(wd);
		end else if (pos_ff == 2'h0) begin
			tx_byte = wd[15:8];
		end else begin
			tx_byte = wd[7:0];
		end
	end

	// Something to read: identity armed or measurement running
	logic avail;
	assign avail = meas_active_in | rdy_ff;

	// Next-state logic of the bus target
	always_comb begin
		nxt_st = st_ff;
		nxt_sh = sh_ff;
		nxt_tx = tx_ff;
		nxt_cnt = cnt_ff;
		nxt_oen = oen_ff;
		nxt_rw = rw_ff;
		nxt_hi = hi_ff;
		nxt_wb = wb_ff;
		nxt_stage = stage_ff;
		nxt_rdy = rdy_ff;
		nxt_msel = msel_ff;
		nxt_pos = pos_ff;
		nxt_word = word_ff;
		nxt_acked = acked_ff;
		if (stop) begin
			// Stop ends any transfer and frees the line
			nxt_st = sid_pkg::ST_IDLE;
			nxt_oen = 1'b1;
		end else if (start) begin
			// Start or repeated start restarts address phase
			nxt_st = sid_pkg::ST_ADDR;
			nxt_cnt = 4'h0;
			nxt_oen = 1'b1;
			nxt_wb = 1'b0;
		end else begin
			case (st_ff)
				sid_pkg::ST_IDLE: begin
					nxt_oen = 1'b1;
				end
				sid_pkg::ST_ADDR: begin
					if (rise) begin
						nxt_sh = {sh_ff[6:0], sda_s2_ff};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (fall && cnt_ff == sid_pkg::BITS_PER_BYTE) begin
						// Read header is nacked with nothing to return
						if (sh_ff[7:1] == DEV_ADDR && (!sh_ff[0] || avail)) begin
							nxt_st = sid_pkg::ST_AACK;
							nxt_oen = 1'b0;
							nxt_rw = sh_ff[0];
							nxt_msel = meas_active_in;
							nxt_pos = 2'h0;
							nxt_word = 3'h0;
						end else begin
							nxt_st = sid_pkg::ST_IDLE;
						end
					end
				end
				sid_pkg::ST_AACK: begin
					if (fall) begin
						nxt_cnt = 4'h0;
						if (rw_ff) begin
							nxt_st = sid_pkg::ST_TX;
							nxt_tx = tx_byte;
							nxt_oen = tx_byte[7];
						end else begin
							nxt_st = sid_pkg::ST_RX;
							nxt_oen = 1'b1;
						end
					end
				end
				sid_pkg::ST_RX: begin
					if (rise) begin
						nxt_sh = {sh_ff[6:0], sda_s2_ff};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (fall && cnt_ff == sid_pkg::BITS_PER_BYTE) begin
						if (meas_active_in) begin
							// Busy measuring: command bytes are nacked
							nxt_st = sid_pkg::ST_IDLE;
						end else begin
							nxt_st = sid_pkg::ST_WACK;
							nxt_oen = 1'b0;
							nxt_wb = ~wb_ff;
							if (!wb_ff) begin
								nxt_hi = sh_ff;
							end else if ({hi_ff, sh_ff} == sid_pkg::CMD_ID_FIRST) begin
								nxt_stage = 1'b1;
								nxt_rdy = 1'b0;
							end else if ({hi_ff, sh_ff} == sid_pkg::CMD_ID_SECOND && stage_ff) begin
								nxt_stage = 1'b0;
								nxt_rdy = 1'b1;
							end else begin
								// Any other command breaks the sequence
								nxt_stage = 1'b0;
								nxt_rdy = 1'b0;
							end
						end
					end
				end
				sid_pkg::ST_WACK: begin
					if (fall) begin
						nxt_st = sid_pkg::ST_RX;
						nxt_cnt = 4'h0;
						nxt_oen = 1'b1;
					end
				end
				sid_pkg::ST_TX: begin
					if (rise) begin
						nxt_cnt = cnt_ff + 4'h1;
					end else if (fall) begin
						if (cnt_ff == sid_pkg::BITS_PER_BYTE) begin
							nxt_st = sid_pkg::ST_MACK;
							nxt_oen = 1'b1;
							nxt_acked = 1'b0;
						end else begin
							nxt_tx = {tx_ff[6:0], 1'b0};
							nxt_oen = tx_ff[6];
						end
					end
				end
				sid_pkg::ST_MACK: begin
					if (rise) begin
						if (sda_s2_ff) begin
							// Host nack: give the line back and wait for stop
							nxt_st = sid_pkg::ST_IDLE;
						end else begin
							nxt_acked = 1'b1;
							if (pos_ff == sid_pkg::CRC_POS) begin
								nxt_pos = 2'h0;
								nxt_word = (word_ff >= nwords) ? word_ff : word_ff + 3'h1;
							end else begin
								nxt_pos = pos_ff + 2'h1;
							end
						end
					end else if (fall && acked_ff) begin
						nxt_st = sid_pkg::ST_TX;
						nxt_cnt = 4'h0;
						nxt_tx = tx_byte;
						nxt_oen = tx_byte[7];
					end
				end
				default: begin
					nxt_st = sid_pkg::ST_IDLE;
					nxt_oen = 1'b1;
				end
			endcase
		end
	end

	// Registers of the bus target
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= sid_pkg::ST_IDLE;
			sh_ff <= 8'h00;
			tx_ff <= 8'h00;
			cnt_ff <= 4'h0;
			oen_ff <= 1'b1;
			rw_ff <= 1'b0;
			hi_ff <= 8'h00;
			wb_ff <= 1'b0;
			stage_ff <= 1'b0;
			rdy_ff <= 1'b0;
			msel_ff <= 1'b0;
			pos_ff <= 2'h0;
			word_ff <= 3'h0;
			acked_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			sh_ff <= nxt_sh;
			tx_ff <= nxt_tx;
			cnt_ff <= nxt_cnt;
			oen_ff <= nxt_oen;
			rw_ff <= nxt_rw;
			hi_ff <= nxt_hi;
			wb_ff <= nxt_wb;
			stage_ff <= nxt_stage;
			rdy_ff <= nxt_rdy;
			msel_ff <= nxt_msel;
			pos_ff <= nxt_pos;
			word_ff <= nxt_word;
			acked_ff <= nxt_acked;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oen_out = oen_ff;
	assign id_ready_out = rdy_ff;

	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	logic ld;
	assign ld = fall & ((st_ff == sid_pkg::ST_AACK & rw_ff) | (st_ff == sid_pkg::ST_MACK & acked_ff));

	property p_id_seq;
		$rose(rdy_ff) |-> $past(stage_ff) && $past({hi_ff, sh_ff}) == sid_pkg::CMD_ID_SECOND;
	endproperty
	a_id_seq: assert property (p_id_seq) else $error("identity armed out of sequence");

	// Past the sixth word only filler may leave; a shifted filler byte is legal
	property p_word_range;
		(ld && !msel_ff && word_ff >= sid_pkg::ID_WORDS) |=> tx_ff == sid_pkg::FILL_BYTE;
	endproperty
	a_word_range: assert property (p_word_range) else $error("data past sixth word");

	property p_prod_first;
		(ld && !msel_ff && word_ff == 3'h0 && pos_ff == 2'h0) |=> tx_ff == PRODUCT_ID[31:24];
	endproperty
	a_prod_first: assert property (p_prod_first) else $error("first byte not product msb");

	property p_serial_first;
		(ld && !msel_ff && word_ff == 3'h2 && pos_ff == 2'h0) |=> tx_ff == serial_in[63:56];
	endproperty
	a_serial_first: assert property (p_serial_first) else $error("serial msb misplaced");

	property p_crc_byte;
		(ld && pos_ff == sid_pkg::CRC_POS && word_ff < nwords) |=> tx_ff == sid_pkg::sid_crc8($past(wd));
	endproperty
	a_crc_byte: assert property (p_crc_byte) else $error("checksum byte wrong");

	property p_crc_example;
		rst_n |-> sid_pkg::sid_crc8(16'hbeef) == 8'h92;
	endproperty
	a_crc_example: assert property (p_crc_example) else $error("checksum algorithm wrong");

	property p_flow_limit;
		flow_cl <= sid_pkg::FLOW_MAX && flow_cl >= sid_pkg::FLOW_MIN;
	endproperty
	a_flow_limit: assert property (p_flow_limit) else $error("flow code beyond limit");

	property p_temp_word;
		(ld && msel_ff && word_ff == 3'h1 && pos_ff == 2'h1) |=> tx_ff == $past(meas_in.temp[7:0]);
	endproperty
	a_temp_word: assert property (p_temp_word) else $error("temperature byte wrong");

	property p_nack_release;
		(st_ff == sid_pkg::ST_MACK && rise && sda_s2_ff && !stop && !start) |=> st_ff == sid_pkg::ST_IDLE ##1 sda_oen_out;
	endproperty
	a_nack_release: assert property (p_nack_release) else $error("line held after host nack");

	property p_busy_refuse;
		(st_ff == sid_pkg::ST_RX && meas_active_in) |=> st_ff != sid_pkg::ST_WACK;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("command acked while measuring");

	c_id_armed: cover property ($rose(rdy_ff));
	c_id_read: cover property (ld && !msel_ff && word_ff == 3'h5 && pos_ff == sid_pkg::CRC_POS);
	c_meas_read: cover property (ld && msel_ff && word_ff == 3'h1);
	c_early_end: cover property (st_ff == sid_pkg::ST_MACK && rise && sda_s2_ff);
endmodule
`default_nettype wire

// File: pkg/sid_pkg.sv
// Constants, carriers and the checksum function of the sensor id readout.
// Assumes one 100 MHz clock domain; bus pins are synchronised in the top.
// Behaviour
// - Identity needs two writes, 0x367c then 0xe102.
// - Identity read returns six words, measurement read two, each with checksum.
// - Product first, then serial, high byte first.
// - Product is 32 bits, low byte is revision.
// - Serial is 64 bits, unique per unit.
// - Checksum covers only the preceding two bytes.
// - Polynomial 0x31, init 0xff, no reflection.
// - Flow sent as signed 16-bit integer.
// - Flow codes clamped to plus/minus 32500.
// - Temperature signed 16-bit; host divides by 200.
// - Host nack plus stop ends read early.
// - Commands refused while measurement is running.
`default_nettype none
package sid_pkg;
	// Command codes of the identity sequence
	localparam logic [15:0] CMD_ID_FIRST = 16'h367c;
	localparam logic [15:0] CMD_ID_SECOND = 16'he102;
	// Checksum definition
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hff;
	localparam logic [7:0] CRC_XOROUT = 8'h00;
	// Flow output limits
	localparam logic signed [15:0] FLOW_MAX = 16'sh7ef4;
	localparam logic signed [15:0] FLOW_MIN = -16'sh7ef4;
	// Words per read and counts
	localparam logic [2:0] ID_WORDS = 3'h6;
	localparam logic [2:0] MEAS_WORDS = 3'h2;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] CRC_POS = 2'h2;
	// Filler byte past the end of the word list
	localparam logic [7:0] FILL_BYTE = 8'hff;

	// Measurement results from the sensing core
	typedef struct packed {
		logic signed [15:0] flow;
		logic signed [15:0] temp;
	} sid_meas_s;

	// Bus target states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_AACK = 7'h04,
		ST_RX = 7'h08,
		ST_WACK = 7'h10,
		ST_TX = 7'h20,
		ST_MACK = 7'h40
	} sid_state_e;

	// Checksum over one 16-bit word, high bit first
	function automatic logic [7:0] sid_crc8(input logic [15:0] data);
		logic [7:0] crc;
		crc = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			if (crc[7] ^ data[i]) begin
				crc = {crc[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				crc = {crc[6:0], 1'b0};
			end
		end
		return crc ^ CRC_XOROUT;
	endfunction
endpackage
`default_nettype wire

// File: testbench/sid_host.sv
// Bus host model: drives the bus clock and open-drain data, reads the wire.
// Assumes a pull-up on the data line and the 100 MHz system clock for pacing.
`default_nettype none
module sid_host (
	// Pacing clock
	input wire logic clk_in,
	// Bus pins
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_drv_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus, both lines released
	initial begin
		scl_out = 1'b1;
		sda_drv_out = 1'b1;
	end

	// Step n clocks, then land just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// One bit slot; data moves only mid low phase, far from the clock fall
	task automatic bit_io(input logic b, output logic s);
		sda_drv_out = b;
		tick(10);
		scl_out = 1'b1;
		tick(20);
		s = sda_in;
		scl_out = 1'b0;
		tick(10);
	endtask

	// Start, also usable as repeated start
	task automatic start_c();
		sda_drv_out = 1'b1;
		tick(10);
		scl_out = 1'b1;
		tick(20);
		sda_drv_out = 1'b0;
		tick(20);
		scl_out = 1'b0;
		tick(10);
	endtask

	// Stop leaves the bus idle
	task automatic stop_c();
		sda_drv_out = 1'b0;
		tick(10);
		scl_out = 1'b1;
		tick(20);
		sda_drv_out = 1'b1;
		tick(20);
	endtask

	// Byte out, high bit first; ak is high when the line was pulled low
	task automatic send_byte(input logic [7:0] d, output logic ak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ak = ~s;
	endtask

	// Byte in, then ack or not-ack from the host
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~ack, s);
	endtask

	// One command in its own write transfer
	task automatic wr_cmd(input logic [6:0] a, input logic [15:0] c, output logic [2:0] ak);
		start_c();
		send_byte({a, 1'b0}, ak[2]);
		send_byte(c[15:8], ak[1]);
		send_byte(c[7:0], ak[0]);
		stop_c();
	endtask

	// Read n bytes; the last is answered with not-ack, then stop
	task automatic rd_bytes(input logic [6:0] a, input int n, output logic ak,
		output logic [7:0] q[$]);
		logic [7:0] d;
		q = {};
		start_c();
		send_byte({a, 1'b1}, ak);
		for (int i = 0; i < n && ak; i++) begin
			get_byte(i < n - 1, d);
			q.push_back(d);
		end
		stop_c();
	endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench of the identity readout, driven through the bus host model.
// Assumes a pull-up on the data line; expected bytes come from the bench's own model.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] ADDR = 7'h2b;
	localparam logic [31:0] PROD = 32'h5a3c7e11; // Arbitrary value
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic scl, sda_drv, sda_wire, dev_sda, dev_oen, id_rdy, meas_act, ak;
	logic [2:0] ak3;
	logic [7:0] q[$];
	logic [15:0] w[6];
	logic [31:0] rng = 32'hed54a6b0;
	logic [63:0] serial;
	logic signed [15:0] fl[6];
	sid_pkg::sid_meas_s meas;
	int error_cnt = 0;
	int tests_run = 0;

	// Free running 100 MHz clock
	always #5 clk_in = ~clk_in;
	// Open-drain wire with pull-up
	assign sda_wire = sda_drv & (dev_oen | dev_sda);

	sid_readout #(.DEV_ADDR(ADDR), .PRODUCT_ID(PROD)) i_sid_readout (
		.clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(dev_sda), .sda_oen_out(dev_oen), .meas_in(meas),
		.meas_active_in(meas_act), .serial_in(serial), .id_ready_out(id_rdy));
	sid_host i_sid_host (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
		.sda_drv_out(sda_drv));

	// Xorshift source, fixed seed
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// Bench checksum over one word, high bit first
	function automatic logic [7:0] crc(input logic [15:0] d);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	// Verdict and end of run
	task automatic print_verdict();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Single compare point
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// Read nw words and compare each word and its checksum
	task automatic rd_words(input int nw);
		i_sid_host.rd_bytes(ADDR, 3 * nw, ak, q);
		chk("hdr_ack", ak, 1'b1);
		for (int k = 0; k < nw; k++) begin
			chk("msb", q[3 * k], w[k][15:8]);
			chk("lsb", q[3 * k + 1], w[k][7:0]);
			chk("crc", q[3 * k + 2], crc(w[k]));
		end
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_in);
		error_cnt++;
		print_verdict();
	end

	// Main sequence
	initial begin
		meas = '0;
		meas_act = 1'b0;
		serial = {xs(), xs()};
		repeat (8) @(posedge clk_in);
		#1;
		rstn_in = 1'b1;
		i_sid_host.tick(10);
		// Read with nothing armed is refused
		i_sid_host.rd_bytes(ADDR, 1, ak, q);
		chk("early_hdr", ak, 1'b0);
		// Wrong order does not arm, right order does
		i_sid_host.wr_cmd(ADDR, 16'he102, ak3);
		chk("rdy_wrong", id_rdy, 1'b0);
		i_sid_host.wr_cmd(ADDR, 16'h367c, ak3);
		chk("cmd_ack", ak3, 3'h7);
		chk("rdy_half", id_rdy, 1'b0);
		i_sid_host.wr_cmd(ADDR, 16'he102, ak3);
		chk("rdy_set", id_rdy, 1'b1);
		// Identity read, twice with fresh serials
		for (int r = 0; r < 2; r++) begin
			serial = {xs(), xs()};
			w = '{PROD[31:16], PROD[15:0], serial[63:48], serial[47:32],
				serial[31:16], serial[15:0]};
			rd_words(6);
		end
		// Abort after the first checksum, then line released and read restarts
		i_sid_host.rd_bytes(ADDR, 3, ak, q);
		chk("oen_rel", dev_oen, 1'b1);
		rd_words(6);
		// Foreign command disarms
		i_sid_host.wr_cmd(ADDR, 16'h1234, ak3);
		chk("rdy_clr", id_rdy, 1'b0);
		// Measurement running: data bytes refused, results clamped
		meas_act = 1'b1;
		i_sid_host.wr_cmd(ADDR, 16'h3ff9, ak3);
		chk("meas_cmd", ak3, 3'h4);
		fl = '{16'sh7ef4, 16'sh7ef5, -16'sh7ef5, 16'sh7fff, 16'sh8000, 16'sh0000};
		fl[5] = 16'(xs());
		for (int i = 0; i < 6; i++) begin
			meas.flow = fl[i];
			meas.temp = 16'(xs());
			w[0] = (fl[i] > sid_pkg::FLOW_MAX) ? sid_pkg::FLOW_MAX :
				(fl[i] < sid_pkg::FLOW_MIN) ? sid_pkg::FLOW_MIN : fl[i];
			w[1] = meas.temp;
			rd_words(2);
			// Host scaling keeps every code inside the 65 ml/min output limit
			chk("flow_mlmin", 16'(($signed(w[0]) / 500 <= 65) && ($signed(w[0]) / 500 >= -65)),
				16'h0001);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
